// ===== rtl/irdf_bank.sv
/*
 Holds the integration register bank with its reset-time contents.
 Assumes a plain register port with one-cycle strobes, strap pins steady
 around reset release, and status flags supplied by the clock synthesizer.
*/
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "irdf_params.svh"

// How it works
// - Unassigned bits are zero, read zero
// - Clock output on, both freeze bits set
// - Debug disable bit follows bus error strap
// - Slave enable set when slave strap low
// - Show cycle field resets to 00
// - Privilege bit resets to one
// - Module map bit resets to one
// - Address and rw disables follow bus error
// - Arbitration field resets to 1111
// - Watchdog enabled, shortest timeout at reset
// - Watchdog prescale follows clock mode strap
// - Halt, bus monitor off, timeout 00
// - Multiplier field resets to 00111111
// - Loss detect and loss reset cleared
// - Limp and lock flags untouched by reset
// - Both stop clock bits cleared
// - Periodic level 000, vector 00001111
// - Modulus zero, prescale follows clock strap
// - Port data registers keep contents
// - All direction bits reset to zero
// - Port E assignment follows bus control strap
// - Port F assignment by strap and mode
module irdf_bank
    import irdf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire irdf_bus_req_type bus_req,
    input wire irdf_strap_type straps,
    input wire logic limp_flag_in,
    input wire logic lock_flag_in,
    output logic [15:0] rdata,
    output logic [15:0] module_configuration,
    output logic [7:0] system_protection_control,
    output logic [15:0] clock_synthesizer_control,
    output logic [15:0] periodic_interrupt_control,
    output logic [15:0] periodic_timer_control,
    output logic [7:0] port_ab_direction,
    output logic [7:0] port_e_direction,
    output logic [7:0] port_e_pin_assign,
    output logic [7:0] port_f_direction,
    output logic [7:0] port_f_pin_assign,
    output logic [7:0] port_a_data,
    output logic [7:0] port_b_data,
    output logic [7:0] port_e_data,
    output logic [7:0] port_f_data
);

    // ----------------------------------------
    // Strap capture sequencing
    // ----------------------------------------
    irdf_state_type state_r;
    logic load_w;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= IRDF_ST_RESET;
        else
        begin
            unique case (state_r)
                IRDF_ST_RESET: state_r <= IRDF_ST_LOAD;
                IRDF_ST_LOAD: state_r <= IRDF_ST_RUN;
                IRDF_ST_RUN: state_r <= IRDF_ST_RUN;
                default: state_r <= IRDF_ST_RESET;
            endcase
        end
    end

    // First edge after release captures straps
    assign load_w = (state_r == IRDF_ST_RESET);

    logic wr_mcr, wr_system_protection_control, wr_clock_synthesizer_control, wr_periodic_interrupt_control, wr_periodic_timer_control;
    logic wr_port_ab_direction, wr_port_e_direction, wr_port_e_pin_assign, wr_port_f_direction, wr_port_f_pin_assign;
    logic wr_pa, wr_pb, wr_pe, wr_pf;
    assign wr_mcr = bus_req.wr && bus_req.addr == `IRDF_OFS_MCR;
    assign wr_system_protection_control = bus_req.wr && bus_req.addr == `IRDF_OFS_SYSTEM_PROTECTION_CONTROL;
    assign wr_clock_synthesizer_control = bus_req.wr && bus_req.addr == `IRDF_OFS_CLOCK_SYNTHESIZER_CONTROL;
    assign wr_periodic_interrupt_control = bus_req.wr && bus_req.addr == `IRDF_OFS_PERIODIC_INTERRUPT_CONTROL;
    assign wr_periodic_timer_control = bus_req.wr && bus_req.addr == `IRDF_OFS_PERIODIC_TIMER_CONTROL;
    assign wr_port_ab_direction = bus_req.wr && bus_req.addr == `IRDF_OFS_PORT_AB_DIRECTION;
    assign wr_port_e_direction = bus_req.wr && bus_req.addr == `IRDF_OFS_PORT_E_DIRECTION;
    assign wr_port_e_pin_assign = bus_req.wr && bus_req.addr == `IRDF_OFS_PORT_E_PIN_ASSIGN;
    assign wr_port_f_direction = bus_req.wr && bus_req.addr == `IRDF_OFS_PORT_F_DIRECTION;
    assign wr_port_f_pin_assign = bus_req.wr && bus_req.addr == `IRDF_OFS_PORT_F_PIN_ASSIGN;
    assign wr_pa = bus_req.wr && bus_req.addr == `IRDF_OFS_PORT_A_DATA;
    assign wr_pb = bus_req.wr && bus_req.addr == `IRDF_OFS_PORT_B_DATA;
    assign wr_pe = bus_req.wr && bus_req.addr == `IRDF_OFS_PORT_E_DATA;
    assign wr_pf = bus_req.wr && bus_req.addr == `IRDF_OFS_PORT_F_DATA;

    // ----------------------------------------
    // Module configuration
    // ----------------------------------------
    logic [15:0] mcr_r;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            mcr_r <= `IRDF_MCR_RST;
        else if (wr_mcr)
            mcr_r <= bus_req.wdata & `IRDF_MCR_MASK;
        else if (load_w)
        begin
            mcr_r[`IRDF_MCR_DBGD] <= straps.bus_error_strap_pin;
            mcr_r[`IRDF_MCR_SLV] <= ~straps.slave_strap_pin;
            mcr_r[`IRDF_MCR_ABD] <= straps.bus_error_strap_pin;
            mcr_r[`IRDF_MCR_RWD] <= straps.bus_error_strap_pin;
        end
    end

    // ----------------------------------------
    // System protection control
    // ----------------------------------------
    logic [7:0] system_protection_control_r;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            system_protection_control_r <= `IRDF_SYSTEM_PROTECTION_CONTROL_RST;
        else if (wr_system_protection_control)
            system_protection_control_r <= bus_req.wdata[7:0];
        else if (load_w)
            system_protection_control_r[`IRDF_SYSTEM_PROTECTION_CONTROL_SWP] <= ~straps.clock_mode_strap_pin;
    end

    // ----------------------------------------
    // Clock synthesizer control
    // ----------------------------------------
    logic [7:0] syn_hi_r;
    logic [7:0] syn_lo_r;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syn_hi_r <= `IRDF_CLOCK_SYNTHESIZER_CONTROL_RST;
            syn_lo_r <= `IRDF_BYTE_ZERO;
        end
        else if (wr_clock_synthesizer_control)
        begin
            syn_hi_r <= bus_req.wdata[15:8];
            syn_lo_r <= bus_req.wdata[7:0] & `IRDF_CLOCK_SYNTHESIZER_CONTROL_LOW_MASK;
        end
    end

    // Status flags pass from the synthesizer, never forced by reset
    logic limp_r;
    logic lock_r;
    always_ff @(posedge core_clk)
    begin
        limp_r <= limp_flag_in;
        lock_r <= lock_flag_in;
    end

    logic [15:0] clock_synthesizer_control_w;
    always_comb
    begin
        clock_synthesizer_control_w = {syn_hi_r, syn_lo_r};
        clock_synthesizer_control_w[`IRDF_CLOCK_SYNTHESIZER_CONTROL_LIMP] = limp_r;
        clock_synthesizer_control_w[`IRDF_CLOCK_SYNTHESIZER_CONTROL_LOCK] = lock_r;
    end

    // ----------------------------------------
    // Periodic interrupt and timer
    // ----------------------------------------
    logic [15:0] periodic_interrupt_control_r;
    logic [15:0] periodic_timer_control_r;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            periodic_interrupt_control_r <= `IRDF_PERIODIC_INTERRUPT_CONTROL_RST;
        else if (wr_periodic_interrupt_control)
            periodic_interrupt_control_r <= bus_req.wdata & `IRDF_PERIODIC_INTERRUPT_CONTROL_MASK;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            periodic_timer_control_r <= `IRDF_PERIODIC_TIMER_CONTROL_RST;
        else if (wr_periodic_timer_control)
            periodic_timer_control_r <= bus_req.wdata & `IRDF_PERIODIC_TIMER_CONTROL_MASK;
        else if (load_w)
            periodic_timer_control_r[`IRDF_PERIODIC_TIMER_CONTROL_PTP] <= ~straps.clock_mode_strap_pin;
    end

    // ----------------------------------------
    // Direction and pin assignment
    // ----------------------------------------
    logic [7:0] port_ab_direction_r, port_e_direction_r, port_f_direction_r, port_e_pin_assign_r, port_f_pin_assign_r;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_ab_direction_r <= `IRDF_BYTE_ZERO;
            port_e_direction_r <= `IRDF_BYTE_ZERO;
            port_f_direction_r <= `IRDF_BYTE_ZERO;
        end
        else
        begin
            if (wr_port_ab_direction)
                port_ab_direction_r <= bus_req.wdata[7:0] & `IRDF_PORT_AB_DIRECTION_MASK;
            if (wr_port_e_direction)
                port_e_direction_r <= bus_req.wdata[7:0];
            if (wr_port_f_direction)
                port_f_direction_r <= bus_req.wdata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_e_pin_assign_r <= `IRDF_BYTE_ZERO;
            port_f_pin_assign_r <= `IRDF_BYTE_ZERO;
        end
        else
        begin
            if (wr_port_e_pin_assign)
                port_e_pin_assign_r <= bus_req.wdata[7:0];
            else if (load_w)
                port_e_pin_assign_r <= straps.bus_control_strap_pin ? `IRDF_BYTE_ONES
                                                        : `IRDF_BYTE_ZERO;
            if (wr_port_f_pin_assign)
                port_f_pin_assign_r <= bus_req.wdata[7:0];
            else if (load_w)
                port_f_pin_assign_r <= (straps.irq_pin_strap_pin && !straps.single_chip)
                           ? `IRDF_BYTE_ONES : `IRDF_BYTE_ZERO;
        end
    end

    // ----------------------------------------
    // Port data, kept through reset
    // ----------------------------------------
    logic [7:0] pdata_r [4];
    logic [3:0] pwr_w;
    assign pwr_w = {wr_pf, wr_pe, wr_pb, wr_pa};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_port
            always_ff @(posedge core_clk)
            begin
                if (pwr_w[gi])
                    pdata_r[gi] <= bus_req.wdata[7:0];
            end
        end
    endgenerate

    // ----------------------------------------
    // Read path, data one cycle later
    // ----------------------------------------
    logic [15:0] rdata_nxt;
    always_comb
    begin
        rdata_nxt = `IRDF_WORD_ZERO;
        unique case (bus_req.addr)
            `IRDF_OFS_MCR: rdata_nxt = mcr_r;
            `IRDF_OFS_SYSTEM_PROTECTION_CONTROL: rdata_nxt = {`IRDF_BYTE_ZERO, system_protection_control_r};
            `IRDF_OFS_CLOCK_SYNTHESIZER_CONTROL: rdata_nxt = clock_synthesizer_control_w;
            `IRDF_OFS_PERIODIC_INTERRUPT_CONTROL: rdata_nxt = periodic_interrupt_control_r;
            `IRDF_OFS_PERIODIC_TIMER_CONTROL: rdata_nxt = periodic_timer_control_r;
            `IRDF_OFS_PORT_A_DATA: rdata_nxt = {`IRDF_BYTE_ZERO, pdata_r[0]};
            `IRDF_OFS_PORT_B_DATA: rdata_nxt = {`IRDF_BYTE_ZERO, pdata_r[1]};
            `IRDF_OFS_PORT_AB_DIRECTION: rdata_nxt = {`IRDF_BYTE_ZERO, port_ab_direction_r};
            `IRDF_OFS_PORT_E_DATA: rdata_nxt = {`IRDF_BYTE_ZERO, pdata_r[2]};
            `IRDF_OFS_PORT_E_DIRECTION: rdata_nxt = {`IRDF_BYTE_ZERO, port_e_direction_r};
            `IRDF_OFS_PORT_E_PIN_ASSIGN: rdata_nxt = {`IRDF_BYTE_ZERO, port_e_pin_assign_r};
            `IRDF_OFS_PORT_F_DATA: rdata_nxt = {`IRDF_BYTE_ZERO, pdata_r[3]};
            `IRDF_OFS_PORT_F_DIRECTION: rdata_nxt = {`IRDF_BYTE_ZERO, port_f_direction_r};
            `IRDF_OFS_PORT_F_PIN_ASSIGN: rdata_nxt = {`IRDF_BYTE_ZERO, port_f_pin_assign_r};
            default: rdata_nxt = `IRDF_WORD_ZERO;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= `IRDF_WORD_ZERO;
        else if (bus_req.rd)
            rdata <= rdata_nxt;
        else
            rdata <= `IRDF_WORD_ZERO;
    end

    // ----------------------------------------
    // Register outputs
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        module_configuration <= mcr_r;
        system_protection_control <= system_protection_control_r;
        clock_synthesizer_control <= clock_synthesizer_control_w;
        periodic_interrupt_control <= periodic_interrupt_control_r;
        periodic_timer_control <= periodic_timer_control_r;
        port_ab_direction <= port_ab_direction_r;
        port_e_direction <= port_e_direction_r;
        port_e_pin_assign <= port_e_pin_assign_r;
        port_f_direction <= port_f_direction_r;
        port_f_pin_assign <= port_f_pin_assign_r;
        port_a_data <= pdata_r[0];
        port_b_data <= pdata_r[1];
        port_e_data <= pdata_r[2];
        port_f_data <= pdata_r[3];
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_mcr_fixed_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(state_r == IRDF_ST_LOAD) |-> mcr_r[15:13] == 3'b011 && mcr_r[9:6] == 4'b0011
        && mcr_r[3:0] == 4'hF)
        else $error("Configuration reset fields wrong");
    a_debug_strap: assert property (@(posedge core_clk) disable iff (!rst_n)
        load_w && !wr_mcr |=> mcr_r[12] == $past(straps.bus_error_strap_pin))
        else $error("Debug disable not from strap");
    a_slave_strap: assert property (@(posedge core_clk) disable iff (!rst_n)
        load_w && !wr_mcr |=> mcr_r[11] == !$past(straps.slave_strap_pin))
        else $error("Slave enable not from strap");
    a_pin_disable: assert property (@(posedge core_clk) disable iff (!rst_n)
        load_w && !wr_mcr |=> mcr_r[5:4] == {2{$past(straps.bus_error_strap_pin)}})
        else $error("Pin disables not from strap");
    a_wdog_prescale: assert property (@(posedge core_clk) disable iff (!rst_n)
        load_w && !wr_system_protection_control |=> system_protection_control_r == {1'b1, !$past(straps.clock_mode_strap_pin), 6'h00})
        else $error("Protection control reset wrong");
    a_timer_prescale: assert property (@(posedge core_clk) disable iff (!rst_n)
        load_w && !wr_periodic_timer_control |=> periodic_timer_control_r[8] == !$past(straps.clock_mode_strap_pin))
        else $error("Timer prescale not from strap");
    a_port_e_assign: assert property (@(posedge core_clk) disable iff (!rst_n)
        load_w && !wr_port_e_pin_assign |=> port_e_pin_assign_r == {8{$past(straps.bus_control_strap_pin)}})
        else $error("Port E assignment wrong");
    a_port_f_assign: assert property (@(posedge core_clk) disable iff (!rst_n)
        load_w && !wr_port_f_pin_assign |=> port_f_pin_assign_r ==
        {8{$past(straps.irq_pin_strap_pin) && !$past(straps.single_chip)}})
        else $error("Port F assignment wrong");
    a_strap_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_r == IRDF_ST_RUN && !wr_mcr |=> $stable(mcr_r))
        else $error("Configuration changed without write");

endmodule : irdf_bank

// ===== rtl/irdf_params.svh
/*
 Holds register offsets, field positions, reset values and write masks
 for the integration register bank. Assumes inclusion by the bank module
 and the test bench only.
*/
`ifndef IRDF_PARAMS_SVH
`define IRDF_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define IRDF_ADDR_W 8
`define IRDF_OFS_MCR 8'h00
`define IRDF_OFS_SYSTEM_PROTECTION_CONTROL 8'h04
`define IRDF_OFS_CLOCK_SYNTHESIZER_CONTROL 8'h08
`define IRDF_OFS_PERIODIC_INTERRUPT_CONTROL 8'h0C
`define IRDF_OFS_PERIODIC_TIMER_CONTROL 8'h10
`define IRDF_OFS_PORT_A_DATA 8'h14
`define IRDF_OFS_PORT_B_DATA 8'h18
`define IRDF_OFS_PORT_AB_DIRECTION 8'h1C
`define IRDF_OFS_PORT_E_DATA 8'h20
`define IRDF_OFS_PORT_E_DIRECTION 8'h24
`define IRDF_OFS_PORT_E_PIN_ASSIGN 8'h28
`define IRDF_OFS_PORT_F_DATA 8'h2C
`define IRDF_OFS_PORT_F_DIRECTION 8'h30
`define IRDF_OFS_PORT_F_PIN_ASSIGN 8'h34

// ----------------------------------------
// Fixed reset values and write masks
// ----------------------------------------
`define IRDF_MCR_RST 16'h60CF
`define IRDF_MCR_MASK 16'hFBFF
`define IRDF_SYSTEM_PROTECTION_CONTROL_RST 8'h80
`define IRDF_CLOCK_SYNTHESIZER_CONTROL_RST 8'h3F
`define IRDF_CLOCK_SYNTHESIZER_CONTROL_LOW_MASK 8'hA7
`define IRDF_PERIODIC_INTERRUPT_CONTROL_RST 16'h000F
`define IRDF_PERIODIC_INTERRUPT_CONTROL_MASK 16'h07FF
`define IRDF_PERIODIC_TIMER_CONTROL_RST 16'h0000
`define IRDF_PERIODIC_TIMER_CONTROL_MASK 16'h01FF
`define IRDF_PORT_AB_DIRECTION_MASK 8'h03
`define IRDF_BYTE_ZERO 8'h00
`define IRDF_WORD_ZERO 16'h0000
`define IRDF_BYTE_ONES 8'hFF

// ----------------------------------------
// Strap-driven and status flag bit positions
// ----------------------------------------
`define IRDF_MCR_DBGD 12
`define IRDF_MCR_SLV 11
`define IRDF_MCR_ABD 5
`define IRDF_MCR_RWD 4
`define IRDF_SYSTEM_PROTECTION_CONTROL_SWP 6
`define IRDF_PERIODIC_TIMER_CONTROL_PTP 8
`define IRDF_CLOCK_SYNTHESIZER_CONTROL_LIMP 4
`define IRDF_CLOCK_SYNTHESIZER_CONTROL_LOCK 3

`endif

// ===== rtl/irdf_pkg.sv
/*
 Holds the types of the integration register bank. Assumes no other file.
*/
package irdf_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } irdf_bus_req_type;

    typedef struct packed {
        logic bus_error_strap_pin;
        logic slave_strap_pin;
        logic clock_mode_strap_pin;
        logic bus_control_strap_pin;
        logic irq_pin_strap_pin;
        logic single_chip;
    } irdf_strap_type;

    typedef enum logic [1:0] {
        IRDF_ST_RESET = 2'b00,
        IRDF_ST_LOAD = 2'b01,
        IRDF_ST_RUN = 2'b10
    } irdf_state_type;

endpackage : irdf_pkg

// ===== tb/integration_reset_defaults_test.sv
/*
 Self-checking bench for the integration register bank: reset values,
 strap capture, unimplemented bits, port data kept across reset.
 Assumes the params header and the package are compiled first.
*/
`timescale 1ns/1ps
`include "irdf_params.svh"

`define CHK(nm, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("mismatch %s expected %h seen %h", nm, exp, got); \
        end \
    end

module integration_reset_defaults_test import irdf_pkg::*; ();

// ----------------------------------------
// Signals and instance
// ----------------------------------------
logic core_clk = 1'b0;
logic rst_n;
irdf_bus_req_type bus_req;
irdf_strap_type straps;
logic limp_flag_in;
logic lock_flag_in;
logic [15:0] rdata;
logic [15:0] module_configuration;
logic [7:0] port_f_pin_assign;
logic [7:0] system_protection_control;
logic [15:0] clock_synthesizer_control;
logic [15:0] periodic_interrupt_control;
logic [15:0] periodic_timer_control;
logic [7:0] port_ab_direction;
logic [7:0] port_e_direction;
logic [7:0] port_e_pin_assign;
logic [7:0] port_f_direction;
logic [7:0] port_a_data;
logic [7:0] port_b_data;
logic [7:0] port_e_data;
logic [7:0] port_f_data;
int n_errors;
int total_checks;

irdf_bank dut_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .straps(straps),
    .limp_flag_in(limp_flag_in),
    .lock_flag_in(lock_flag_in),
    .rdata(rdata),
    .module_configuration(module_configuration),
    .system_protection_control(system_protection_control),
    .clock_synthesizer_control(clock_synthesizer_control),
    .periodic_interrupt_control(periodic_interrupt_control),
    .periodic_timer_control(periodic_timer_control),
    .port_ab_direction(port_ab_direction),
    .port_e_direction(port_e_direction),
    .port_e_pin_assign(port_e_pin_assign),
    .port_f_direction(port_f_direction),
    .port_f_pin_assign(port_f_pin_assign),
    .port_a_data(port_a_data),
    .port_b_data(port_b_data),
    .port_e_data(port_e_data),
    .port_f_data(port_f_data)
);

always #20 core_clk = ~core_clk;

// ----------------------------------------
// Bus and reset tasks
// ----------------------------------------
task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
endtask : wr

task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
endtask : rd_chk

task automatic do_reset(input irdf_strap_type s);
    @(posedge core_clk);
    straps <= s;
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
endtask : do_reset

// ----------------------------------------
// Scenarios
// ----------------------------------------
task automatic reset_values(input irdf_strap_type s, input logic limp, input logic lock);
    logic [15:0] mcr;
    logic [15:0] ef;
    logic [15:0] sy;
    logic [15:0] pt;
    mcr = 16'h60cf;
    sy = s.clock_mode_strap_pin ? 16'h0080 : 16'h00c0;
    pt = s.clock_mode_strap_pin ? 16'h0000 : 16'h0100;
    if (s.bus_error_strap_pin)
        mcr = mcr | 16'h1030;
    if (!s.slave_strap_pin)
        mcr = mcr | 16'h0800;
    ef = (s.irq_pin_strap_pin && !s.single_chip) ? 16'h00ff : 16'h0000;
    limp_flag_in <= limp;
    lock_flag_in <= lock;
    do_reset(s);
    rd_chk("mcr", `IRDF_OFS_MCR, mcr);
    rd_chk("system_protection_control", `IRDF_OFS_SYSTEM_PROTECTION_CONTROL, sy);
    rd_chk("clock_synthesizer_control", `IRDF_OFS_CLOCK_SYNTHESIZER_CONTROL,
        {8'h3f, 3'b000, limp, lock, 3'b000});
    rd_chk("periodic_interrupt_control", `IRDF_OFS_PERIODIC_INTERRUPT_CONTROL, 16'h000f);
    rd_chk("periodic_timer_control", `IRDF_OFS_PERIODIC_TIMER_CONTROL, pt);
    rd_chk("port_ab_direction", `IRDF_OFS_PORT_AB_DIRECTION, 16'h0000);
    rd_chk("port_e_direction", `IRDF_OFS_PORT_E_DIRECTION, 16'h0000);
    rd_chk("port_f_direction", `IRDF_OFS_PORT_F_DIRECTION, 16'h0000);
    rd_chk("port_e_pin_assign", `IRDF_OFS_PORT_E_PIN_ASSIGN,
        s.bus_control_strap_pin ? 16'h00ff : 16'h0000);
    rd_chk("port_f_pin_assign", `IRDF_OFS_PORT_F_PIN_ASSIGN, ef);
    `CHK("mcr_out", mcr, module_configuration)
    `CHK("port_f_pin_assign_out", ef[7:0], port_f_pin_assign)
    `CHK("system_protection_control_out", sy[7:0], system_protection_control)
    `CHK("clock_synthesizer_control_out", {8'h3f, 3'b000, limp, lock, 3'b000}, clock_synthesizer_control)
    `CHK("periodic_interrupt_control_out", 16'h000f, periodic_interrupt_control)
    `CHK("periodic_timer_control_out", pt, periodic_timer_control)
    `CHK("dir_out", 32'h0000_0000, {port_ab_direction, port_e_direction, port_f_direction, 8'h00})
    `CHK("port_e_pin_assign_out", {8{s.bus_control_strap_pin}}, port_e_pin_assign)
endtask : reset_values

task automatic unimpl_bits;
    logic [7:0] ofs [10];
    logic [15:0] msk [10];
    ofs = '{`IRDF_OFS_MCR, `IRDF_OFS_SYSTEM_PROTECTION_CONTROL, `IRDF_OFS_CLOCK_SYNTHESIZER_CONTROL, `IRDF_OFS_PERIODIC_INTERRUPT_CONTROL,
        `IRDF_OFS_PERIODIC_TIMER_CONTROL, `IRDF_OFS_PORT_AB_DIRECTION, `IRDF_OFS_PORT_E_DIRECTION, `IRDF_OFS_PORT_E_PIN_ASSIGN,
        `IRDF_OFS_PORT_F_DIRECTION, `IRDF_OFS_PORT_F_PIN_ASSIGN};
    msk = '{16'hfbff, 16'h00ff, 16'hffa7, 16'h07ff, 16'h01ff, 16'h0003,
        16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff};
    limp_flag_in <= 1'b0;
    lock_flag_in <= 1'b0;
    foreach (ofs[i])
    begin
        wr(ofs[i], 16'hffff);
        rd_chk("masked", ofs[i], msk[i]);
    end
    wr(8'h38, 16'hffff);
    rd_chk("unmapped", 8'h38, 16'h0000);
    rd_chk("unaligned", 8'h02, 16'h0000);
endtask : unimpl_bits

task automatic ports_kept;
    logic [7:0] pofs [4];
    pofs = '{`IRDF_OFS_PORT_A_DATA, `IRDF_OFS_PORT_B_DATA, `IRDF_OFS_PORT_E_DATA, `IRDF_OFS_PORT_F_DATA};
    foreach (pofs[i])
        wr(pofs[i], {8'h00, 8'ha5 ^ 8'(i)});
    do_reset(straps);
    foreach (pofs[i])
        rd_chk("port", pofs[i], {8'h00, 8'ha5 ^ 8'(i)});
    `CHK("port_out", 32'ha5a4_a7a6, {port_a_data, port_b_data, port_e_data, port_f_data})
endtask : ports_kept

task automatic straps_held;
    do_reset(irdf_strap_type'(6'b100110));
    straps <= irdf_strap_type'(6'b011001);
    rd_chk("mcr_held", `IRDF_OFS_MCR, 16'h78ff);
    rd_chk("port_e_pin_assign_held", `IRDF_OFS_PORT_E_PIN_ASSIGN, 16'h00ff);
    rd_chk("port_f_pin_assign_held", `IRDF_OFS_PORT_F_PIN_ASSIGN, 16'h00ff);
    wr(`IRDF_OFS_PORT_E_PIN_ASSIGN, 16'h0012);
    rd_chk("port_e_pin_assign_wr", `IRDF_OFS_PORT_E_PIN_ASSIGN, 16'h0012);
    wr(`IRDF_OFS_MCR, 16'h0000);
    rd_chk("mcr_wr", `IRDF_OFS_MCR, 16'h0000);
endtask : straps_held

// ----------------------------------------
// Verdict
// ----------------------------------------
task automatic results;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
    begin
        $display("Run complete: PASS");
    end
    else
    begin
        $display("Run complete: FAIL");
    end
    $finish;
endtask : results

initial
begin
    rst_n = 1'b0;
    bus_req = '0;
    straps = '0;
    limp_flag_in = 1'b0;
    lock_flag_in = 1'b0;
    n_errors = 0;
    total_checks = 0;
    reset_values(irdf_strap_type'(6'b100110), 1'b1, 1'b0);
    reset_values(irdf_strap_type'(6'b011011), 1'b0, 1'b1);
    reset_values(irdf_strap_type'(6'b110100), 1'b1, 1'b1);
    unimpl_bits();
    ports_kept();
    straps_held();
    results();
end

endmodule : integration_reset_defaults_test
